/* File: design/gpio_port_pkg.sv */
package gpio_port_pkg;

    // ****************
    // register byte offsets on the bus
    // ****************
    localparam logic [7:0] OFF_PORT_ONE_DATA = 8'h00;
    localparam logic [7:0] OFF_PORT_ONE_DIR = 8'h04;
    localparam logic [7:0] OFF_PORT_SIX_DATA = 8'h08;
    localparam logic [7:0] OFF_PORT_SIX_DIR = 8'h0c;
    localparam logic [7:0] OFF_OSC_PORT_DATA = 8'h10;
    localparam logic [7:0] OFF_OSC_PORT_DIR = 8'h14;
    localparam logic [7:0] OFF_STANDBY_CTRL = 8'h18;
    localparam logic [7:0] OFF_SYSTEM_CFG = 8'h1c;

    // ****************
    // implemented pin bits of each port
    // ****************
    localparam logic [7:0] PORT_ONE_MASK = 8'h04;
    localparam logic [7:0] PORT_SIX_MASK = 8'h1c;
    localparam logic [7:0] OSC_PORT_MASK = 8'h07;

    localparam int PIN_TIMER_A = 2;
    localparam int PIN_TIMER_B = 3;
    localparam int PIN_TIMER_CLK = 4;
    localparam int PIN_OSC_IN = 0;
    localparam int PIN_OSC_OUT = 1;
    localparam int PIN_RESET = 2;

    // ****************
    // control bit positions and reset values
    // ****************
    localparam int STANDBY_PIN_FLOAT_BIT = 4;
    localparam int RESET_PIN_SELECT_BIT = 0;
    localparam int MAIN_OSC_PIN_SELECT_BIT = 1;

    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic STANDBY_PIN_FLOAT_RESET = 1'b0;
    localparam logic MAIN_OSC_PIN_SELECT_RESET = 1'b0;
    localparam logic RESET_PIN_SELECT_RESET = 1'b1;
    localparam logic [31:0] BUS_READ_ZERO = 32'h0000_0000;

    // ****************
    // pin drive carrier
    // ****************
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } pin_drive_s;

    localparam pin_drive_s DRIVE_FLOAT = '{out: 8'h00, oe: 8'h00};

endpackage : gpio_port_pkg

/* File: design/gpio_port_control.sv */
`timescale 1ns/100ps
`default_nettype none

// Contract
// - direction bit one makes the pin a port output
// - port output pin drives its data latch bit
// - data writes always update latch; input pins do not drive it
// - direction bit zero makes the pin a port input
// - output pin data read returns the latch value
// - input pin read returns pin level; read-modify-write returns latch
// - peripheral output enable routes peripheral output to the pin
// - peripheral-driven pin reads pin level; read-modify-write reads latch
// - peripheral input pin reads return pin level
// - reset clears every direction bit, pins become inputs
// - float bit set in stop or watch forces all pins high impedance
// - in forced float the input path is blocked and reads low
// - float bit clear in standby keeps configuration and output levels
// - pins float during reset; software configures them afterwards
// - three-pin port uses bits two, three and four only
// - oscillator select zero gives the two oscillator pins to the oscillator
// - reset select one gives the reset-shared pin to external reset
// - open-drain reset-shared pin floats when driving one
module gpio_port_control #(
    parameter int ADDR_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // ****************
    // classic wishbone slave
    // ****************
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // ****************
    // cpu and clock controller side, same clock
    // ****************
    input wire logic read_modify_write_access_i,
    input wire logic standby_mode_i,
    // ****************
    // shared peripherals
    // ****************
    input wire logic timer1_output_a_en_i,
    input wire logic timer1_output_a_i,
    input wire logic timer1_output_b_en_i,
    input wire logic timer1_output_b_i,
    output logic timer1_clock_input_o,
    output logic main_osc_enable_o,
    output logic ext_reset_n_o,
    // ****************
    // pins
    // ****************
    input wire logic [7:0] port_one_pins_i,
    input wire logic [7:0] port_six_pins_i,
    input wire logic [7:0] osc_port_pins_i,
    output gpio_port_pkg::pin_drive_s port_one_pins_o,
    output gpio_port_pkg::pin_drive_s port_six_pins_o,
    output gpio_port_pkg::pin_drive_s osc_port_pins_o
);

    // ****************
    // helpers
    // ****************
    function automatic logic [7:0] read_value(
        input logic [7:0] latch,
        input logic [7:0] dir,
        input logic [7:0] level,
        input logic [7:0] periph,
        input logic read_modify_write_access,
        input logic [7:0] mask
    );
        logic [7:0] from_latch;
        from_latch = read_modify_write_access ? 8'hff : (dir & ~periph);
        return ((latch & from_latch) | (level & ~from_latch)) & mask;
    endfunction : read_value

    function automatic gpio_port_pkg::pin_drive_s port_drive(
        input logic [7:0] latch,
        input logic [7:0] dir,
        input logic [7:0] mask
    );
        gpio_port_pkg::pin_drive_s d;
        d.oe = dir & mask;
        d.out = latch & d.oe;
        return d;
    endfunction : port_drive

    // ****************
    // pin synchronisers
    // ****************
    logic [7:0] p1_meta_q;
    logic [7:0] p1_sync_q;
    logic [7:0] p6_meta_q;
    logic [7:0] p6_sync_q;
    logic [7:0] pf_meta_q;
    logic [7:0] pf_sync_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            p1_meta_q <= 8'h00;
            p1_sync_q <= 8'h00;
            p6_meta_q <= 8'h00;
            p6_sync_q <= 8'h00;
            pf_meta_q <= 8'h00;
            pf_sync_q <= 8'h00;
        end else begin
            p1_meta_q <= port_one_pins_i;
            p1_sync_q <= p1_meta_q;
            p6_meta_q <= port_six_pins_i;
            p6_sync_q <= p6_meta_q;
            pf_meta_q <= osc_port_pins_i;
            pf_sync_q <= pf_meta_q;
        end
    end

    // ****************
    // registers
    // ****************
    logic [7:0] port_one_data_latch_q;
    logic [7:0] port_one_direction_q;
    logic [7:0] port_six_data_latch_q;
    logic [7:0] port_six_direction_q;
    logic [7:0] osc_port_data_latch_q;
    logic [7:0] osc_port_direction_q;
    logic standby_pin_float_q;
    logic main_osc_pin_select_q;
    logic reset_pin_select_q;
    logic ack_q;
    logic [31:0] rdata_q;

    logic req;
    logic wr_en;
    logic [7:0] wbyte;
    logic [7:0] adr8;

    assign req = wb_cyc_i & wb_stb_i;
    // write lands at the edge where the master sees ack
    assign wr_en = req & wb_we_i & ack_q & wb_sel_i[0];
    assign wbyte = wb_dat_i[7:0];
    assign adr8 = 8'(wb_adr_i);

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction : hit

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_one_data_latch_q <= gpio_port_pkg::LATCH_RESET;
            port_six_data_latch_q <= gpio_port_pkg::LATCH_RESET;
            osc_port_data_latch_q <= gpio_port_pkg::LATCH_RESET;
        end else if (wr_en) begin
            // latch always takes the write, whatever the direction
            if (hit(adr8, gpio_port_pkg::OFF_PORT_ONE_DATA)) begin
                port_one_data_latch_q <= wbyte & gpio_port_pkg::PORT_ONE_MASK;
            end
            if (hit(adr8, gpio_port_pkg::OFF_PORT_SIX_DATA)) begin
                port_six_data_latch_q <= wbyte & gpio_port_pkg::PORT_SIX_MASK;
            end
            if (hit(adr8, gpio_port_pkg::OFF_OSC_PORT_DATA)) begin
                osc_port_data_latch_q <= wbyte & gpio_port_pkg::OSC_PORT_MASK;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_one_direction_q <= gpio_port_pkg::DIR_RESET;
            port_six_direction_q <= gpio_port_pkg::DIR_RESET;
            osc_port_direction_q <= gpio_port_pkg::DIR_RESET;
        end else if (wr_en) begin
            if (hit(adr8, gpio_port_pkg::OFF_PORT_ONE_DIR)) begin
                port_one_direction_q <= wbyte & gpio_port_pkg::PORT_ONE_MASK;
            end
            if (hit(adr8, gpio_port_pkg::OFF_PORT_SIX_DIR)) begin
                port_six_direction_q <= wbyte & gpio_port_pkg::PORT_SIX_MASK;
            end
            if (hit(adr8, gpio_port_pkg::OFF_OSC_PORT_DIR)) begin
                osc_port_direction_q <= wbyte & gpio_port_pkg::OSC_PORT_MASK;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            standby_pin_float_q <= gpio_port_pkg::STANDBY_PIN_FLOAT_RESET;
            main_osc_pin_select_q <= gpio_port_pkg::MAIN_OSC_PIN_SELECT_RESET;
            reset_pin_select_q <= gpio_port_pkg::RESET_PIN_SELECT_RESET;
        end else if (wr_en) begin
            if (hit(adr8, gpio_port_pkg::OFF_STANDBY_CTRL)) begin
                standby_pin_float_q <= wbyte[gpio_port_pkg::STANDBY_PIN_FLOAT_BIT];
            end
            if (hit(adr8, gpio_port_pkg::OFF_SYSTEM_CFG)) begin
                main_osc_pin_select_q <= wbyte[gpio_port_pkg::MAIN_OSC_PIN_SELECT_BIT];
                reset_pin_select_q <= wbyte[gpio_port_pkg::RESET_PIN_SELECT_BIT];
            end
        end
    end

    // ****************
    // standby override and input levels
    // ****************
    logic float_all;
    logic [7:0] p1_level;
    logic [7:0] p6_level;
    logic [7:0] pf_level;
    logic [7:0] pf_avail;

    // combinational on the mode, so exit restores pins at the next clock edge through the drive registers
    assign float_all = standby_mode_i & standby_pin_float_q;
    // blocked inputs read low to avoid leakage on open pins
    assign p1_level = float_all ? 8'h00 : p1_sync_q;
    assign p6_level = float_all ? 8'h00 : p6_sync_q;
    assign pf_level = float_all ? 8'h00 : pf_sync_q;

    always_comb begin
        pf_avail = gpio_port_pkg::OSC_PORT_MASK;
        if (!main_osc_pin_select_q) begin
            pf_avail[gpio_port_pkg::PIN_OSC_IN] = 1'b0;
            pf_avail[gpio_port_pkg::PIN_OSC_OUT] = 1'b0;
        end
        if (reset_pin_select_q) begin
            pf_avail[gpio_port_pkg::PIN_RESET] = 1'b0;
        end
    end

    // ****************
    // peripheral routing and pin drive
    // ****************
    logic [7:0] p6_periph_en;
    logic [7:0] p6_periph_val;
    gpio_port_pkg::pin_drive_s p1_drive_d;
    gpio_port_pkg::pin_drive_s p6_drive_d;
    gpio_port_pkg::pin_drive_s pf_drive_d;
    gpio_port_pkg::pin_drive_s p1_drive_q;
    gpio_port_pkg::pin_drive_s p6_drive_q;
    gpio_port_pkg::pin_drive_s pf_drive_q;

    always_comb begin
        p6_periph_en = 8'h00;
        p6_periph_val = 8'h00;
        p6_periph_en[gpio_port_pkg::PIN_TIMER_A] = timer1_output_a_en_i;
        p6_periph_val[gpio_port_pkg::PIN_TIMER_A] = timer1_output_a_i;
        p6_periph_en[gpio_port_pkg::PIN_TIMER_B] = timer1_output_b_en_i;
        p6_periph_val[gpio_port_pkg::PIN_TIMER_B] = timer1_output_b_i;
    end

    always_comb begin
        p1_drive_d = port_drive(port_one_data_latch_q, port_one_direction_q,
                                gpio_port_pkg::PORT_ONE_MASK);
        p6_drive_d = port_drive(port_six_data_latch_q, port_six_direction_q,
                                gpio_port_pkg::PORT_SIX_MASK);
        // peripheral wins over the latch on its pins
        p6_drive_d.oe = p6_drive_d.oe | p6_periph_en;
        p6_drive_d.out = (p6_drive_d.out & ~p6_periph_en)
                       | (p6_periph_val & p6_periph_en);
        pf_drive_d = port_drive(osc_port_data_latch_q, osc_port_direction_q, pf_avail);
        // open drain: only a low is driven
        if (pf_drive_d.out[gpio_port_pkg::PIN_RESET]) begin
            pf_drive_d.oe[gpio_port_pkg::PIN_RESET] = 1'b0;
        end
        pf_drive_d.out[gpio_port_pkg::PIN_RESET] = 1'b0;
        if (float_all) begin
            p1_drive_d = gpio_port_pkg::DRIVE_FLOAT;
            p6_drive_d = gpio_port_pkg::DRIVE_FLOAT;
            pf_drive_d = gpio_port_pkg::DRIVE_FLOAT;
        end
    end

    // float bit clear: pins keep following the normal settings
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            p1_drive_q <= gpio_port_pkg::DRIVE_FLOAT;
            p6_drive_q <= gpio_port_pkg::DRIVE_FLOAT;
            pf_drive_q <= gpio_port_pkg::DRIVE_FLOAT;
        end else begin
            p1_drive_q <= p1_drive_d;
            p6_drive_q <= p6_drive_d;
            pf_drive_q <= pf_drive_d;
        end
    end

    assign port_one_pins_o = p1_drive_q;
    assign port_six_pins_o = p6_drive_q;
    assign osc_port_pins_o = pf_drive_q;

    // ****************
    // peripheral inputs
    // ****************
    logic timer1_clock_q;
    logic main_osc_enable_q;
    logic ext_reset_n_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer1_clock_q <= 1'b0;
            main_osc_enable_q <= 1'b1;
            ext_reset_n_q <= 1'b1;
        end else begin
            // pin level goes to the timer whatever the direction
            timer1_clock_q <= p6_level[gpio_port_pkg::PIN_TIMER_CLK];
            main_osc_enable_q <= ~main_osc_pin_select_q;
            // reset path is not a port input, so it ignores the blocking
            ext_reset_n_q <= ~reset_pin_select_q
                           | pf_sync_q[gpio_port_pkg::PIN_RESET];
        end
    end

    assign timer1_clock_input_o = timer1_clock_q;
    assign main_osc_enable_o = main_osc_enable_q;
    assign ext_reset_n_o = ext_reset_n_q;

    // ****************
    // bus answer
    // ****************
    logic [7:0] rbyte;
    logic read_modify_write_access;

    assign read_modify_write_access = read_modify_write_access_i;

    always_comb begin
        rbyte = 8'h00;
        unique case (adr8)
            gpio_port_pkg::OFF_PORT_ONE_DATA: rbyte = read_value(port_one_data_latch_q,
                port_one_direction_q, p1_level, 8'h00, read_modify_write_access, gpio_port_pkg::PORT_ONE_MASK);
            gpio_port_pkg::OFF_PORT_ONE_DIR: rbyte = port_one_direction_q;
            gpio_port_pkg::OFF_PORT_SIX_DATA: rbyte = read_value(port_six_data_latch_q,
                port_six_direction_q, p6_level, p6_periph_en, read_modify_write_access,
                gpio_port_pkg::PORT_SIX_MASK);
            gpio_port_pkg::OFF_PORT_SIX_DIR: rbyte = port_six_direction_q;
            // pins handed away read as zero
            gpio_port_pkg::OFF_OSC_PORT_DATA: rbyte = read_value(osc_port_data_latch_q,
                osc_port_direction_q, pf_level, 8'h00, read_modify_write_access, pf_avail);
            gpio_port_pkg::OFF_OSC_PORT_DIR: rbyte = osc_port_direction_q;
            gpio_port_pkg::OFF_STANDBY_CTRL: begin
                rbyte[gpio_port_pkg::STANDBY_PIN_FLOAT_BIT] = standby_pin_float_q;
            end
            gpio_port_pkg::OFF_SYSTEM_CFG: begin
                rbyte[gpio_port_pkg::MAIN_OSC_PIN_SELECT_BIT] = main_osc_pin_select_q;
                rbyte[gpio_port_pkg::RESET_PIN_SELECT_BIT] = reset_pin_select_q;
            end
            default: rbyte = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            // one wait cycle, then ack for one cycle
            ack_q <= req & ~ack_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_q <= gpio_port_pkg::BUS_READ_ZERO;
        end else if (req & ~ack_q & ~wb_we_i) begin
            rdata_q <= {24'h000000, rbyte};
        end else begin
            rdata_q <= gpio_port_pkg::BUS_READ_ZERO;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;

endmodule : gpio_port_control

`default_nettype wire

/* File: dv/pin_world.sv */
`timescale 1ns/100ps
`default_nettype none
module pin_world (
    input wire logic clk_i,
    input wire gpio_port_pkg::pin_drive_s drive_i,
    input wire logic [7:0] ext_en_i,
    input wire logic [7:0] ext_val_i,
    output logic [7:0] level_o
);
    // no pulls on these lines, so a released pin wanders instead of holding
    logic [7:0] wander_q = 8'h5a;
    always_ff @(posedge clk_i) begin
        wander_q <= ~wander_q;
    end
    assign level_o = (drive_i.oe & drive_i.out) | (~drive_i.oe & ext_en_i & ext_val_i)
        | (~drive_i.oe & ~ext_en_i & wander_q);
endmodule : pin_world
`default_nettype wire

/* File: dv/gpio_port_control_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module gpio_port_control_checker #(
    parameter int ADDR_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic standby_mode_i,
    input wire logic timer1_output_a_en_i,
    input wire logic timer1_output_a_i,
    input wire logic timer1_clock_input_o,
    input wire logic main_osc_enable_o,
    input wire logic ext_reset_n_o,
    input wire gpio_port_pkg::pin_drive_s port_one_pins_o,
    input wire gpio_port_pkg::pin_drive_s port_six_pins_o,
    input wire gpio_port_pkg::pin_drive_s osc_port_pins_o
);
    // ****************
    // shadow of the control bits the pins depend on
    // ****************
    logic float_q;
    logic rst_sel_q;
    logic wr_ack;
    assign wr_ack = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            float_q <= gpio_port_pkg::STANDBY_PIN_FLOAT_RESET;
        end else if (wr_ack && wb_adr_i == ADDR_W'(gpio_port_pkg::OFF_STANDBY_CTRL)) begin
            float_q <= wb_dat_i[4];
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rst_sel_q <= gpio_port_pkg::RESET_PIN_SELECT_RESET;
        end else if (wr_ack && wb_adr_i == ADDR_W'(gpio_port_pkg::OFF_SYSTEM_CFG)) begin
            rst_sel_q <= wb_dat_i[0];
        end
    end
    // ****************
    // properties
    // ****************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence bus_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence float_held;
        (standby_mode_i && float_q) [*2];
    endsequence
    reset_float_a: assert property ($fell(rst_i) |-> port_one_pins_o.oe == 8'h00
        && port_six_pins_o.oe == 8'h00 && osc_port_pins_o.oe == 8'h00 && ext_reset_n_o)
        else $error("pins driven after reset");
    bus_answer_a: assert property (bus_req |=> wb_ack_o)
        else $error("request not acknowledged next cycle");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge longer than one cycle");
    read_idle_a: assert property (wb_dat_o[31:8] == 24'h0 && (wb_ack_o || wb_dat_o == 32'h0))
        else $error("read data outside its cycle");
    unused_bits_a: assert property (((port_one_pins_o.oe | port_one_pins_o.out)
        & ~gpio_port_pkg::PORT_ONE_MASK) == 8'h00 && ((port_six_pins_o.oe | port_six_pins_o.out)
        & ~gpio_port_pkg::PORT_SIX_MASK) == 8'h00) else $error("unused pin bit driven");
    osc_select_a: assert property (main_osc_enable_o && $past(main_osc_enable_o)
        |-> osc_port_pins_o.oe[1:0] == 2'b00) else $error("oscillator pin driven by port");
    reset_pin_a: assert property (rst_sel_q && $past(rst_sel_q) |-> !osc_port_pins_o.oe[2])
        else $error("reset pin driven by port");
    open_drain_a: assert property (osc_port_pins_o.oe[2] |-> !osc_port_pins_o.out[2])
        else $error("open drain pin driven high");
    float_hiz_a: assert property (float_held |=> port_one_pins_o.oe == 8'h00
        && port_six_pins_o.oe == 8'h00 && osc_port_pins_o.oe == 8'h00)
        else $error("pin driven in float standby");
    float_block_a: assert property ((standby_mode_i && float_q) [*4] |=> !timer1_clock_input_o)
        else $error("input not blocked in float standby");
    timer_route_a: assert property ((timer1_output_a_en_i && !standby_mode_i) [*2] |=>
        port_six_pins_o.oe[2] && port_six_pins_o.out[2] == $past(timer1_output_a_i))
        else $error("timer output not routed to pin");
endmodule : gpio_port_control_checker

bind gpio_port_control gpio_port_control_checker #(.ADDR_W(ADDR_W)) i_gpio_port_control_checker (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .standby_mode_i(standby_mode_i),
    .timer1_output_a_en_i(timer1_output_a_en_i), .timer1_output_a_i(timer1_output_a_i),
    .timer1_clock_input_o(timer1_clock_input_o), .main_osc_enable_o(main_osc_enable_o),
    .ext_reset_n_o(ext_reset_n_o), .port_one_pins_o(port_one_pins_o),
    .port_six_pins_o(port_six_pins_o), .osc_port_pins_o(osc_port_pins_o));
`default_nettype wire

/* File: dv/gpio_port_control_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(what, exp, got) begin num_checks++; if ((got) !== (exp)) begin mismatches++; \
    $display("wrong value %s expected %h seen %h", what, exp, got); end end
module gpio_port_control_tb_top;
    logic clk_i, rst_i, cyc, stb, we, read_modify_write_access, sb, ta_en, ta, tb_en, tbv, ack, tclk, osc_en, xrst_n;
    logic [7:0] adr, rv, lvl1, lvl6, lvlf, xen6, xv6, xenf, xvf;
    logic [3:0] sel;
    logic [31:0] dat_w, dat_r;
    gpio_port_pkg::pin_drive_s p1, p6, pf;
    int mismatches, num_checks;
    gpio_port_control i_gpio_port_control (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w),
        .wb_dat_o(dat_r), .wb_ack_o(ack), .read_modify_write_access_i(read_modify_write_access), .standby_mode_i(sb),
        .timer1_output_a_en_i(ta_en), .timer1_output_a_i(ta), .timer1_output_b_en_i(tb_en),
        .timer1_output_b_i(tbv), .timer1_clock_input_o(tclk), .main_osc_enable_o(osc_en),
        .ext_reset_n_o(xrst_n), .port_one_pins_i(lvl1), .port_six_pins_i(lvl6),
        .osc_port_pins_i(lvlf), .port_one_pins_o(p1), .port_six_pins_o(p6), .osc_port_pins_o(pf));
    pin_world i_pin_world_one (.clk_i(clk_i), .drive_i(p1), .ext_en_i(8'h00), .ext_val_i(8'h00),
        .level_o(lvl1));
    pin_world i_pin_world_six (.clk_i(clk_i), .drive_i(p6), .ext_en_i(xen6), .ext_val_i(xv6),
        .level_o(lvl6));
    pin_world i_pin_world_osc (.clk_i(clk_i), .drive_i(pf), .ext_en_i(xenf), .ext_val_i(xvf),
        .level_o(lvlf));
    // ****************
    // bus and closing tasks
    // ****************
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'h1;
        dat_w <= {24'h0, d};
        do @(posedge clk_i); while (ack !== 1'b1);
        rv = dat_r[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask : bus
    task automatic settle();
        repeat (4) @(posedge clk_i);
    endtask : settle
    // ****************
    // scenarios
    // ****************
    task automatic t_reset();
        bus(0, gpio_port_pkg::OFF_PORT_SIX_DIR, 8'h00);
        `CHK("six dir", 8'h00, rv)
        bus(0, gpio_port_pkg::OFF_OSC_PORT_DIR, 8'h00);
        `CHK("osc dir", 8'h00, rv)
        bus(0, gpio_port_pkg::OFF_SYSTEM_CFG, 8'h00);
        `CHK("sys cfg", 8'h01, rv)
        bus(1, 8'h20, 8'hff);
        bus(0, 8'h20, 8'h00);
        `CHK("unmapped", 8'h00, rv)
        $display("test reset done");
    endtask : t_reset
    task automatic t_port_out();
        bus(1, gpio_port_pkg::OFF_PORT_SIX_DIR, 8'hff);
        bus(1, gpio_port_pkg::OFF_PORT_SIX_DATA, 8'hf4);
        bus(1, gpio_port_pkg::OFF_PORT_ONE_DIR, 8'h04);
        bus(1, gpio_port_pkg::OFF_PORT_ONE_DATA, 8'h04);
        settle();
        `CHK("six oe", 8'h1c, p6.oe)
        `CHK("six out", 8'h14, p6.out)
        `CHK("one out", 8'h04, p1.out & p1.oe)
        bus(0, gpio_port_pkg::OFF_PORT_SIX_DIR, 8'h00);
        `CHK("six dir", 8'h1c, rv)
        bus(0, gpio_port_pkg::OFF_PORT_SIX_DATA, 8'h00);
        `CHK("six data", 8'h14, rv)
        $display("test port_out done");
    endtask : t_port_out
    task automatic t_port_in();
        xen6 <= 8'h1c;
        xv6 <= 8'h18;
        bus(1, gpio_port_pkg::OFF_PORT_SIX_DIR, 8'h00);
        bus(1, gpio_port_pkg::OFF_PORT_SIX_DATA, 8'h04);
        settle();
        `CHK("six oe", 8'h00, p6.oe)
        `CHK("timer clock", 1'b1, tclk)
        bus(0, gpio_port_pkg::OFF_PORT_SIX_DATA, 8'h00);
        `CHK("pin read", 8'h18, rv)
        read_modify_write_access <= 1'b1;
        bus(0, gpio_port_pkg::OFF_PORT_SIX_DATA, 8'h00);
        read_modify_write_access <= 1'b0;
        `CHK("rmw read", 8'h04, rv)
        $display("test port_in done");
    endtask : t_port_in
    task automatic t_periph();
        // direction stays zero for the timer clock input
        xen6 <= 8'h10;
        ta_en <= 1'b1;
        ta <= 1'b0;
        tb_en <= 1'b1;
        tbv <= 1'b1;
        settle();
        `CHK("periph oe", 8'h0c, p6.oe)
        `CHK("periph out", 8'h08, p6.out & 8'h0c)
        bus(0, gpio_port_pkg::OFF_PORT_SIX_DATA, 8'h00);
        `CHK("periph read", 8'h18, rv)
        read_modify_write_access <= 1'b1;
        bus(0, gpio_port_pkg::OFF_PORT_SIX_DATA, 8'h00);
        read_modify_write_access <= 1'b0;
        `CHK("periph rmw", 8'h04, rv)
        ta_en <= 1'b0; // timer outputs released before port use
        tb_en <= 1'b0;
        $display("test periph done");
    endtask : t_periph
    task automatic t_standby();
        bus(1, gpio_port_pkg::OFF_PORT_SIX_DIR, 8'h1c);
        bus(1, gpio_port_pkg::OFF_PORT_SIX_DATA, 8'h0c);
        sb <= 1'b1;
        settle();
        `CHK("keep oe", 8'h1c, p6.oe)
        `CHK("keep out", 8'h0c, p6.out)
        sb <= 1'b0;
        bus(1, gpio_port_pkg::OFF_STANDBY_CTRL, 8'h10);
        sb <= 1'b1;
        settle();
        `CHK("float oe", 16'h0000, {p6.oe, p1.oe})
        `CHK("blocked clock", 1'b0, tclk)
        sb <= 1'b0;
        settle();
        `CHK("wake oe", 8'h1c, p6.oe)
        `CHK("wake out", 8'h0c, p6.out)
        bus(1, gpio_port_pkg::OFF_STANDBY_CTRL, 8'h00);
        $display("test standby done");
    endtask : t_standby
    task automatic t_osc();
        bus(1, gpio_port_pkg::OFF_OSC_PORT_DIR, 8'h07);
        bus(1, gpio_port_pkg::OFF_OSC_PORT_DATA, 8'h07);
        xenf <= 8'h04;
        xvf <= 8'h00;
        settle();
        `CHK("osc oe", 8'h00, pf.oe)
        `CHK("osc enable", 1'b1, osc_en)
        `CHK("ext reset", 1'b0, xrst_n)
        xenf <= 8'h00;
        bus(1, gpio_port_pkg::OFF_SYSTEM_CFG, 8'h02);
        settle();
        `CHK("osc oe", 8'h03, pf.oe)
        `CHK("osc enable", 1'b0, osc_en)
        bus(1, gpio_port_pkg::OFF_OSC_PORT_DATA, 8'h03);
        settle();
        `CHK("od drive", 16'h0307, {pf.out, pf.oe})
        `CHK("ext reset", 1'b1, xrst_n)
        $display("test osc done");
    endtask : t_osc
    // ****************
    // clock, reset, sequence and watchdog
    // ****************
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    initial begin
        {rst_i, cyc, stb, we, read_modify_write_access, sb, ta_en, ta, tb_en, tbv} = 10'h200;
        {adr, sel, dat_w, xen6, xv6, xenf, xvf} = '0;
        mismatches = 0;
        num_checks = 0;
        @(posedge clk_i);
        #1;
        `CHK("reset oe", 8'h00, p6.oe | p1.oe | pf.oe)
        @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_port_out();
        t_port_in();
        t_periph();
        t_standby();
        t_osc();
        finish_test();
    end
    initial begin
        repeat (3000) @(posedge clk_i);
        mismatches++;
        finish_test();
    end
endmodule : gpio_port_control_tb_top
`default_nettype wire
